// ---- hdl/dcdma_channel.sv ----
// Descriptor-chained DMA channel with register port and byte bus master
//
// What this block does
// R1: source address is config high plus descriptor low
// R2: destination address likewise from both halves
// R3: each burst acquires, moves, releases the spoke
// R4: software keeps same-spoke bursts at 16 or less
// R5: request-per-burst clear: one request whole transaction
// R6: request-per-burst set: request before every burst
// R7: initial descriptor pointer, each descriptor links next
// R8: preserve uses working copy, else updates descriptor
// R9: descriptor holds 12-bit transfer byte count
// R10: increment-source property advances source address
// R11: increment-destination property advances destination address
// R12: swap reverses bytes in 2- or 4-byte groups
// R13: auto-execute chains next descriptor without request
// R14: completion property gives 2-clock done pulse
// R15: termination edge stops transaction during a burst
// R16: hardware request edge, level or derived sensitivity
// R17: request disabled means processor request only
// R18: transfer count split into burst-sized pieces
// R19: request starts transaction with channel and descriptor
// R20: count drops per byte, zero ends descriptor
// R21: wait for arbiter grant before each burst
// R22: reset disables channel, clears working state, done low
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dcdma_channel (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Trigger side
  input  wire logic        drq,
  input  wire logic        drq_is_level,
  input  wire logic        trq,
  output logic             done_pulse,
  // Spoke bus master
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic      [31:0] bus_addr,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic      [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_rdata
);
  import dcdma_pkg::*;

  // Byte address of a transfer: high half, low base, offset with optional swap
  function automatic logic [31:0] xfer_addr(input logic [15:0] hi, input logic [15:0] lo,
                                            input logic [CNT_W-1:0] k, input logic inc,
                                            input logic [PROP_W-1:0] pr);
    logic [CNT_W-1:0] eff;
    eff = k;
    if (pr[PR_SWAP]) begin
      eff = k ^ (pr[PR_SWAP4] ? 12'h003 : 12'h001);                  // [R12]
    end
    xfer_addr = {hi, lo + (inc ? {4'h0, eff} : 16'h0000)};           // [R1] [R2] [R10] [R11]
  endfunction

  // Register file and descriptor memory
  logic [31:0]         ctrl_r,  ctrl_nxt;
  logic [31:0]         hi_r,    hi_nxt;
  logic [TD_IW-1:0]    init_r,  init_nxt;
  logic [31:0]         td_lo_r  [TD_N];
  logic [31:0]         td_cfg_r [TD_N];
  logic [31:0]         td_lo_nxt  [TD_N];
  logic [31:0]         td_cfg_nxt [TD_N];
  logic [31:0]         rdata_r, rdata_nxt;
  // Sequencer state
  dcdma_state_e        st_r,    st_nxt;
  logic [TD_IW-1:0]    cur_r,   cur_nxt;
  logic [TD_IW-1:0]    next_r,  next_nxt;
  logic [15:0]         wsrc_r,  wsrc_nxt;
  logic [15:0]         wdst_r,  wdst_nxt;
  logic [CNT_W-1:0]    cnt_r,   cnt_nxt;
  logic [CNT_W-1:0]    k_r,     k_nxt;
  logic [BURST_W-1:0]  bleft_r, bleft_nxt;
  logic [PROP_W-1:0]   prop_r,  prop_nxt;
  logic                mid_r,   mid_nxt;
  logic [1:0]          dcnt_r,  dcnt_nxt;
  logic                done_r,  done_nxt;
  logic                breq_r,  breq_nxt;
  logic [31:0]         baddr_r, baddr_nxt;
  logic                brd_r,   brd_nxt;
  logic                bwr_r,   bwr_nxt;
  logic [7:0]          bwd_r,   bwd_nxt;
  // Cross-group strobes
  logic                wb_en;
  logic [15:0]         wb_src, wb_dst;
  logic                ld;
  logic [TD_IW-1:0]    ld_td;
  logic                req, req_take, term_edge;
  logic                td_sel;
  logic [TD_IW-1:0]    td_idx;
  logic [BURST_W-1:0]  burst;
  logic                en, pres, rpb;

  assign en     = ctrl_r[CTL_EN];
  assign pres   = ctrl_r[CTL_PRES];
  assign rpb    = ctrl_r[CTL_RPB];
  assign burst  = ctrl_r[CTL_BURST_LSB +: BURST_W];
  assign td_sel = (reg_addr[9:8] == TD_REGION) && (reg_addr[7:6] == 2'h0);
  assign td_idx = reg_addr[5:3];

  // Request and termination conditioning
  dcdma_trig u_trig (
    .mclk         (mclk),
    .reset        (reset),
    .mode         (dcdma_mode_e'(ctrl_r[CTL_MODE_LSB +: 2])),
    .drq_is_level (drq_is_level),
    .drq          (drq),
    .cpu_req      (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTL_CPU_REQ]),
    .req_take     (req_take),
    .trq          (trq),
    .req          (req),
    .term_edge    (term_edge)
  );

  // Register writes, in-place writeback and read mux
  always_comb begin
    ctrl_nxt   = ctrl_r;
    hi_nxt     = hi_r;
    init_nxt   = init_r;
    td_lo_nxt  = td_lo_r;
    td_cfg_nxt = td_cfg_r;
    rdata_nxt  = 32'h0000_0000;
    if (reg_wr) begin
      if (reg_addr == OFS_CTRL) begin
        ctrl_nxt = {1'b0, reg_wdata[30:0]};
      end else if (reg_addr == OFS_ADDR_HI) begin
        hi_nxt = reg_wdata;
      end else if (reg_addr == OFS_TD_INIT) begin
        init_nxt = reg_wdata[TD_IW-1:0];                               // [R7]
      end else if (td_sel && !reg_addr[2]) begin
        td_lo_nxt[td_idx] = reg_wdata;
      end else if (td_sel) begin
        td_cfg_nxt[td_idx] = reg_wdata;
      end
    end
    if (wb_en) begin
      td_lo_nxt[cur_r] = {wb_dst, wb_src};                             // [R8]
      td_cfg_nxt[cur_r][CFG_CNT_LSB +: CNT_W] = cnt_r;                 // [R8]
    end
    if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (reg_addr == OFS_ADDR_HI) begin
        rdata_nxt = hi_r;
      end else if (reg_addr == OFS_TD_INIT) begin
        rdata_nxt = {29'h0000_0000, init_r};
      end else if (reg_addr == OFS_STATUS) begin
        rdata_nxt = {4'h0, cnt_r, 5'h00, cur_r, 6'h00, st_r != ST_IDLE || mid_r, mid_r};
      end else if (td_sel) begin
        rdata_nxt = reg_addr[2] ? td_cfg_r[td_idx] : td_lo_r[td_idx];
      end
    end
  end

  // Register file storage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_r  <= CTRL_RST;                                              // [R22]
      hi_r    <= 32'h0000_0000;
      init_r  <= '0;
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < TD_N; i++) begin
        td_lo_r[i]  <= 32'h0000_0000;
        td_cfg_r[i] <= 32'h0000_0000;
      end
    end else begin
      ctrl_r   <= ctrl_nxt;
      hi_r     <= hi_nxt;
      init_r   <= init_nxt;
      rdata_r  <= rdata_nxt;
      td_lo_r  <= td_lo_nxt;
      td_cfg_r <= td_cfg_nxt;
    end
  end

  // Channel sequencer
  always_comb begin
    st_nxt    = st_r;
    cur_nxt   = cur_r;
    next_nxt  = next_r;
    wsrc_nxt  = wsrc_r;
    wdst_nxt  = wdst_r;
    cnt_nxt   = cnt_r;
    k_nxt     = k_r;
    bleft_nxt = bleft_r;
    prop_nxt  = prop_r;
    mid_nxt   = mid_r;
    dcnt_nxt  = (dcnt_r != 2'h0) ? dcnt_r - 2'h1 : 2'h0;
    breq_nxt  = breq_r;
    baddr_nxt = baddr_r;
    brd_nxt   = 1'b0;
    bwr_nxt   = 1'b0;
    bwd_nxt   = bwd_r;
    wb_en     = 1'b0;
    wb_src    = 16'(xfer_addr(16'h0000, wsrc_r, k_r, prop_r[PR_INC_SRC], 7'h00));
    wb_dst    = 16'(xfer_addr(16'h0000, wdst_r, k_r, prop_r[PR_INC_DST], 7'h00));
    ld        = 1'b0;
    ld_td     = cur_r;
    req_take  = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (!en) begin
          cur_nxt = init_r;                                            // [R7]
          mid_nxt = 1'b0;
        end else if (req) begin
          req_take  = 1'b1;                                            // [R19]
          bleft_nxt = burst;
          if (mid_r) begin
            st_nxt = ST_ARB;                                           // [R6]
          end else begin
            ld = 1'b1;                                                 // [R19]
          end
        end
      end
      ST_ARB: begin
        breq_nxt = 1'b1;                                               // [R3]
        if (bus_gnt && breq_r) begin
          st_nxt    = ST_RD;                                           // [R21]
          brd_nxt   = 1'b1;
          baddr_nxt = xfer_addr(hi_r[15:0], wsrc_r, k_r, prop_r[PR_INC_SRC], prop_r);
        end
      end
      ST_RD: begin
        st_nxt = ST_CAP;
      end
      ST_CAP: begin
        st_nxt    = ST_WR;
        bwr_nxt   = 1'b1;
        bwd_nxt   = bus_rdata;
        baddr_nxt = xfer_addr(hi_r[31:16], wdst_r, k_r, prop_r[PR_INC_DST], 7'h00);
      end
      ST_WR: begin
        cnt_nxt   = cnt_r - 12'h001;                                   // [R20]
        k_nxt     = k_r + 12'h001;
        bleft_nxt = bleft_r - 7'h01;
        if (cnt_r == 12'h001 || bleft_r == 7'h01) begin
          st_nxt = ST_REL;                                             // [R18]
        end else begin
          st_nxt    = ST_RD;
          brd_nxt   = 1'b1;
          baddr_nxt = xfer_addr(hi_r[15:0], wsrc_r, k_nxt, prop_r[PR_INC_SRC], prop_r);
        end
      end
      ST_REL: begin
        breq_nxt  = 1'b0;                                              // [R3]
        wb_en     = !pres;                                             // [R8]
        wsrc_nxt  = wb_src;                                            // [R10]
        wdst_nxt  = wb_dst;                                            // [R11]
        k_nxt     = 12'h000;
        bleft_nxt = burst;
        if (cnt_r == 12'h000) begin
          mid_nxt = 1'b0;                                              // [R20]
          cur_nxt = next_r;                                            // [R7]
          if (prop_r[PR_DONE]) begin
            dcnt_nxt = DONE_CYC;                                       // [R14]
          end
          if (prop_r[PR_AUTO] && en) begin
            ld    = 1'b1;                                              // [R13]
            ld_td = next_r;
          end else begin
            st_nxt = ST_IDLE;                                          // [R13]
          end
        end else if (rpb) begin
          mid_nxt = 1'b1;
          st_nxt  = ST_IDLE;                                           // [R6]
        end else begin
          st_nxt = ST_ARB;                                             // [R5]
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // Descriptor load: preserved original feeds the working copy
    if (ld) begin
      cur_nxt   = ld_td;
      wsrc_nxt  = td_lo_r[ld_td][15:0];                                // [R1] [R8]
      wdst_nxt  = td_lo_r[ld_td][31:16];                               // [R2]
      cnt_nxt   = td_cfg_r[ld_td][CFG_CNT_LSB +: CNT_W];               // [R9]
      next_nxt  = td_cfg_r[ld_td][CFG_NEXT_LSB +: TD_IW];              // [R7]
      prop_nxt  = td_cfg_r[ld_td][CFG_PROP_LSB +: PROP_W];
      k_nxt     = 12'h000;
      bleft_nxt = burst;
      mid_nxt   = 1'b1;
      st_nxt    = (td_cfg_r[ld_td][CFG_CNT_LSB +: CNT_W] == 12'h000) ? ST_REL : ST_ARB;
    end
    // Termination edge during a burst stops the chain
    if ((st_r == ST_RD || st_r == ST_CAP || st_r == ST_WR) && term_edge && prop_r[PR_TERM]) begin
      st_nxt   = ST_IDLE;                                              // [R15]
      breq_nxt = 1'b0;
      brd_nxt  = 1'b0;
      bwr_nxt  = 1'b0;
      mid_nxt  = 1'b0;
      cur_nxt  = init_r;
    end
    done_nxt = (dcnt_nxt != 2'h0);                                     // [R14]
  end

  // Sequencer storage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r    <= ST_IDLE;                                              // [R22]
      cur_r   <= '0;
      next_r  <= '0;
      wsrc_r  <= 16'h0000;
      wdst_r  <= 16'h0000;
      cnt_r   <= 12'h000;
      k_r     <= 12'h000;
      bleft_r <= 7'h00;
      prop_r  <= 7'h00;
      mid_r   <= 1'b0;
      dcnt_r  <= 2'h0;
      done_r  <= 1'b0;                                                 // [R22]
      breq_r  <= 1'b0;
      baddr_r <= 32'h0000_0000;
      brd_r   <= 1'b0;
      bwr_r   <= 1'b0;
      bwd_r   <= 8'h00;
    end else begin
      st_r    <= st_nxt;
      cur_r   <= cur_nxt;
      next_r  <= next_nxt;
      wsrc_r  <= wsrc_nxt;
      wdst_r  <= wdst_nxt;
      cnt_r   <= cnt_nxt;
      k_r     <= k_nxt;
      bleft_r <= bleft_nxt;
      prop_r  <= prop_nxt;
      mid_r   <= mid_nxt;
      dcnt_r  <= dcnt_nxt;
      done_r  <= done_nxt;
      breq_r  <= breq_nxt;
      baddr_r <= baddr_nxt;
      brd_r   <= brd_nxt;
      bwr_r   <= bwr_nxt;
      bwd_r   <= bwd_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata  = rdata_r;
  assign done_pulse = done_r;
  assign bus_req    = breq_r;
  assign bus_addr   = baddr_r;
  assign bus_rd     = brd_r;
  assign bus_wr     = bwr_r;
  assign bus_wdata  = bwd_r;
endmodule // dcdma_channel
`default_nettype wire

// ---- hdl/dcdma_pkg.sv ----
// Package: register map, field layout and enumerations of the DMA channel
package dcdma_pkg;
  // Register port byte offsets
  localparam logic [9:0] OFS_CTRL    = 10'h000;
  localparam logic [9:0] OFS_ADDR_HI = 10'h004;
  localparam logic [9:0] OFS_TD_INIT = 10'h008;
  localparam logic [9:0] OFS_STATUS  = 10'h00C;
  localparam logic [1:0] TD_REGION   = 2'h1;   // reg_addr[9:8] of descriptor memory
  // Sizes
  localparam int TD_N    = 8;
  localparam int TD_IW   = 3;
  localparam int CNT_W   = 12;
  localparam int BURST_W = 7;
  localparam int PROP_W  = 7;
  // Control register fields
  localparam int CTL_EN        = 0;
  localparam int CTL_PRES      = 1;
  localparam int CTL_RPB       = 2;
  localparam int CTL_MODE_LSB  = 3;
  localparam int CTL_BURST_LSB = 8;
  localparam int CTL_CPU_REQ   = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  // Descriptor config word fields
  localparam int CFG_CNT_LSB  = 0;
  localparam int CFG_NEXT_LSB = 16;
  localparam int CFG_PROP_LSB = 24;
  // Descriptor property bits
  localparam int PR_INC_SRC = 0;
  localparam int PR_INC_DST = 1;
  localparam int PR_SWAP    = 2;
  localparam int PR_SWAP4   = 3;
  localparam int PR_AUTO    = 4;
  localparam int PR_DONE    = 5;
  localparam int PR_TERM    = 6;
  // Done pulse length in bus clocks
  localparam logic [1:0] DONE_CYC = 2'h2;
  // Hardware request sensitivity
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_EDGE    = 2'b01,
    MODE_LEVEL   = 2'b10,
    MODE_DERIVED = 2'b11
  } dcdma_mode_e;
  // Channel sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ARB  = 3'b001,
    ST_RD   = 3'b010,
    ST_CAP  = 3'b011,
    ST_WR   = 3'b100,
    ST_REL  = 3'b101
  } dcdma_state_e;
endpackage

// ---- hdl/dcdma_trig.sv ----
// Request and termination input conditioning for the DMA channel
`timescale 1ns/1ps
`default_nettype none
module dcdma_trig (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // Configuration
  input  wire dcdma_pkg::dcdma_mode_e mode,
  input  wire logic                  drq_is_level,
  // Request sources
  input  wire logic                  drq,
  input  wire logic                  cpu_req,
  input  wire logic                  req_take,
  input  wire logic                  trq,
  // Conditioned outputs
  output logic                       req,
  output logic                       term_edge
);
  import dcdma_pkg::*;
  logic drq_d_r, drq_d_nxt;
  logic trq_d_r, trq_d_nxt;
  logic pend_r,  pend_nxt;
  logic lvl;

  // Sensitivity select and pending latch, set wins over take
  always_comb begin
    lvl       = (mode == MODE_LEVEL) || (mode == MODE_DERIVED && drq_is_level); // [R16]
    drq_d_nxt = drq;
    trq_d_nxt = trq;
    pend_nxt  = pend_r & ~req_take;
    if (cpu_req) begin
      pend_nxt = 1'b1;                                                           // [R17]
    end
    if (mode != MODE_OFF && !lvl && drq && !drq_d_r) begin
      pend_nxt = 1'b1;                                                           // [R16]
    end
    req       = pend_r || (mode != MODE_OFF && lvl && drq);                      // [R17]
    term_edge = trq && !trq_d_r;                                                 // [R15]
  end

  // Edge history and pending flag
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      drq_d_r <= 1'b0;
      trq_d_r <= 1'b0;
      pend_r  <= 1'b0;
    end else begin
      drq_d_r <= drq_d_nxt;
      trq_d_r <= trq_d_nxt;
      pend_r  <= pend_nxt;
    end
  end
endmodule // dcdma_trig
`default_nettype wire

// ---- sim/dcdma_channel_asserts.sv ----
// Port checker for the DMA channel
`timescale 1ns/1ps
`default_nettype none
module dcdma_channel_asserts (
  // Clock, reset, register port
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [9:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Trigger side
  input wire logic        drq,
  input wire logic        drq_is_level,
  input wire logic        trq,
  input wire logic        done_pulse,
  // Spoke bus
  input wire logic        bus_req,
  input wire logic        bus_gnt,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata
);
  import dcdma_pkg::*;
  logic [31:0] hi_r;
  logic [31:0] hi_nxt;
  // Shadow of the upper address halves
  always_comb hi_nxt = (reg_wr && reg_addr == OFS_ADDR_HI) ? reg_wdata : hi_r;
  always_ff @(posedge mclk or posedge reset)
    if (reset) hi_r <= 32'h0;
    else hi_r <= hi_nxt;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Steps of a done pulse and of one byte move
  sequence s_done2;
    done_pulse [*2] ##1 !done_pulse;
  endsequence
  sequence s_move;
    !bus_rd && !bus_wr ##1 bus_wr;
  endsequence
  a_done_width: assert property ($rose(done_pulse) |-> s_done2)
    else $error("done pulse width wrong");
  a_byte_order: assert property (disable iff (reset || trq) bus_rd |=> s_move)
    else $error("read not followed by write");
  a_src_high: assert property (bus_rd |-> bus_addr[31:16] == hi_r[15:0])
    else $error("source upper half wrong");
  a_dst_high: assert property (bus_wr |-> bus_addr[31:16] == hi_r[31:16])
    else $error("destination upper half wrong");
  a_wr_data: assert property (bus_wr |-> bus_wdata == $past(bus_rdata))
    else $error("written byte not the byte read");
  a_gnt_held: assert property ((bus_rd || bus_wr) |-> bus_req && bus_gnt)
    else $error("bus access without grant");
  a_spoke_release: assert property (bus_req && !bus_rd && $past(bus_wr) |=> !bus_req)
    else $error("spoke not released between bursts");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_done_quiet: assert property ($rose(done_pulse) |-> !bus_rd && !bus_wr)
    else $error("done raised during a byte move");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |-> !done_pulse && !bus_req && !bus_wr)
    else $error("outputs active in reset");
endmodule // dcdma_channel_asserts
bind dcdma_channel dcdma_channel_asserts chk_u (.mclk, .reset, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .drq, .drq_is_level, .trq, .done_pulse, .bus_req,
  .bus_gnt, .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata);
`default_nettype wire

// ---- sim/dcdma_mem_model.sv ----
// Spoke arbiter and byte memory facing the channel
`timescale 1ns/1ps
`default_nettype none
module dcdma_mem_model (
  // Clock and arbitration
  input  wire logic        mclk,
  input  wire logic        hold_off,
  // Spoke bus
  input  wire logic        bus_req,
  output logic             bus_gnt,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata
);
  logic [7:0] wmem [0:255];
  int         wr_n = 0;
  // Grant only while the processor leaves the spoke free
  assign bus_gnt = bus_req && !hold_off;
  // Read byte stands one cycle, inverted filler otherwise
  initial bus_rdata = 8'h00;
  always @(posedge mclk) begin
    if (bus_rd) bus_rdata <= bus_addr[7:0] ^ bus_addr[23:16] ^ 8'h3C;
    else bus_rdata <= ~bus_rdata;
    if (bus_wr) begin
      wmem[bus_addr[7:0]] <= bus_wdata;
      wr_n <= wr_n + 1;
    end
  end
endmodule // dcdma_mem_model
`default_nettype wire

// ---- sim/test_dcdma_channel.sv ----
// Self-checking testbench for the DMA channel
`timescale 1ns/1ps
`default_nettype none
module test_dcdma_channel;
  import dcdma_pkg::*;
  logic        mclk, reset, reg_wr, reg_rd, drq, drq_is_level, trq, hold_off;
  logic [9:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, bus_addr;
  logic [7:0]  bus_wdata, bus_rdata;
  logic        done_pulse, bus_req, bus_gnt, bus_rd, bus_wr, req_d, done_d;
  int          fail_count = 0, tests_run = 0, done_n = 0, bst_n = 0;
  dcdma_channel dut_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .drq, .drq_is_level, .trq, .done_pulse, .bus_req, .bus_gnt,
    .bus_addr, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata);
  dcdma_mem_model mem_u (.mclk, .hold_off, .bus_req, .bus_gnt, .bus_addr, .bus_rd,
    .bus_wr, .bus_wdata, .bus_rdata);
  // Clock and burst/done counters
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    req_d <= bus_req;
    done_d <= done_pulse;
    if (bus_req && !req_d) bst_n <= bst_n + 1;
    if (done_pulse && !done_d) done_n <= done_n + 1;
  end
  // Verdict and end of run
  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare and report
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask
  // Word builders and expected source byte
  function automatic logic [31:0] ctl(input logic [1:0] md, input logic [6:0] b,
                                      input logic [2:0] f);
    ctl = {f[2], 16'h0, b, 3'h0, md, f[1], f[0], 1'b1};
  endfunction
  function automatic logic [31:0] cfg(input logic [11:0] c, input logic [2:0] nx,
                                      input logic [6:0] pr);
    cfg = {1'b0, pr, 5'h00, nx, 4'h0, c};
  endfunction
  function automatic logic [7:0] src_b(input logic [31:0] a);
    src_b = a[7:0] ^ a[23:16] ^ 8'h3C;
  endfunction
  // Descriptor load and bounded waits
  task automatic td(input logic [2:0] i, input logic [31:0] lo, input logic [31:0] c);
    wr({TD_REGION, 2'h0, i, 3'h0}, lo);
    wr({TD_REGION, 2'h0, i, 3'h4}, c);
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 300; i++) begin
      rd(OFS_STATUS, s);
      if (s[1] === 1'b0) break;
    end
    chk("idle", 32'(s[1]), 32'h0);
  endtask
  task automatic wait_wr(input int n);
    for (int i = 0; i < 300 && mem_u.wr_n < n; i++) @(posedge mclk);
    chk("write seen", 32'(mem_u.wr_n >= n), 32'h1);
  endtask
  // Reset values and unmapped address
  task automatic t_reset;
    logic [31:0] d;
    rd(OFS_CTRL, d); chk("ctrl", d, CTRL_RST);
    rd(OFS_STATUS, d); chk("status", d, 32'h0);
    wr(10'h010, 32'hFFFF_FFFF);
    rd(10'h010, d); chk("unmapped", d, 32'h0);
    rd({TD_REGION, 8'h04}, d); chk("td cfg", d, 32'h0);
  endtask
  // Two-burst copy, in-place update
  task automatic t_copy;
    logic [31:0] d;
    int w0, b0, d0;
    w0 = mem_u.wr_n; b0 = bst_n; d0 = done_n;
    wr(OFS_ADDR_HI, 32'h5678_1234);
    td(0, 32'h0080_0010, cfg(12'd6, 3'd0, 7'h23));
    wr(OFS_CTRL, ctl(2'd0, 7'd4, 3'b100));
    wait_idle;
    chk("bursts", 32'(bst_n - b0), 32'd2);
    chk("writes", 32'(mem_u.wr_n - w0), 32'd6);
    chk("done", 32'(done_n - d0), 32'd1);
    for (int k = 0; k < 6; k++)
      chk("copy", 32'(mem_u.wmem[8'h80 + k]), 32'(src_b(32'h1234_0010 + k)));
    rd({TD_REGION, 8'h04}, d); chk("count", 32'(d[11:0]), 32'h0);
    rd({TD_REGION, 8'h00}, d); chk("lo", d, 32'h0086_0016);
  endtask
  // Edge then level request per burst, fixed destination, preserve
  task automatic t_rpb;
    logic [31:0] d;
    int w0;
    wr(OFS_CTRL, 32'h0);
    td(1, 32'h00C0_0020, cfg(12'd4, 3'd1, 7'h01));
    wr(OFS_TD_INIT, 32'h1);
    wr(OFS_CTRL, ctl(2'd1, 7'd2, 3'b011));
    w0 = mem_u.wr_n;
    for (int p = 0; p < 2; p++) begin
      if (p) wr(OFS_CTRL, ctl(2'd2, 7'd2, 3'b011));
      drq <= 1'b1;
      @(posedge mclk);
      drq <= 1'b0;
      wait_wr(w0 + 2 * p + 2);
      repeat (30) @(posedge mclk);
      chk("burst per req", 32'(mem_u.wr_n - w0), 32'(2 * p + 2));
    end
    chk("fixed dst", 32'(mem_u.wmem[8'hC0]), 32'(src_b(32'h1234_0023)));
    rd({TD_REGION, 8'h0C}, d); chk("kept", d, cfg(12'd4, 3'd1, 7'h01));
  endtask
  // Two- and four-byte swaps
  task automatic t_swap;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, 32'h0);
      td(2, 32'h00A0_0040, cfg(12'd4, 3'd2, m ? 7'h0F : 7'h07));
      wr(OFS_TD_INIT, 32'h2);
      wr(OFS_CTRL, ctl(2'd0, 7'd4, 3'b101));
      wait_idle;
      for (int k = 0; k < 4; k++)
        chk("swap", 32'(mem_u.wmem[8'hA0 + k]),
            32'(src_b(32'h1234_0040 + (k ^ (m ? 3 : 1)))));
    end
  endtask
  // Chain with auto-next, then wait for request
  task automatic t_chain;
    int w0, d0;
    wr(OFS_CTRL, 32'h0);
    td(3, 32'h00D0_0050, cfg(12'd2, 3'd4, 7'h13));
    td(4, 32'h00D0_0050, cfg(12'd2, 3'd5, 7'h23));
    td(5, 32'h00D0_0050, cfg(12'd2, 3'd5, 7'h23));
    wr(OFS_TD_INIT, 32'h3);
    w0 = mem_u.wr_n; d0 = done_n;
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, ctl(2'd0, 7'd2, 3'b101));
      wait_idle;
      chk("chain writes", 32'(mem_u.wr_n - w0), 32'(4 + 2 * p));
      chk("chain done", 32'(done_n - d0), 32'(p + 1));
    end
  endtask
  // Grant stall, derived level request, disabled request
  task automatic t_stall;
    int w0;
    wr(OFS_CTRL, 32'h0);
    td(6, 32'h00E0_0060, cfg(12'd3, 3'd6, 7'h03));
    wr(OFS_TD_INIT, 32'h6);
    w0 = mem_u.wr_n;
    hold_off <= 1'b1;
    drq_is_level <= 1'b1;
    drq <= 1'b1;
    wr(OFS_CTRL, ctl(2'd3, 7'd3, 3'b001));
    repeat (20) @(posedge mclk);
    chk("stalled", 32'(mem_u.wr_n - w0), 32'd0);
    hold_off <= 1'b0;
    wait_wr(w0 + 1);
    drq <= 1'b0;
    wait_idle;
    chk("level", 32'(mem_u.wr_n - w0), 32'd3);
    drq_is_level <= 1'b0;
    wr(OFS_CTRL, ctl(2'd0, 7'd3, 3'b001));
    w0 = mem_u.wr_n;
    drq <= 1'b1;
    repeat (2) @(posedge mclk);
    drq <= 1'b0;
    repeat (30) @(posedge mclk);
    chk("off", 32'(mem_u.wr_n - w0), 32'd0);
  endtask
  // Termination in mid-burst
  task automatic t_term;
    int w0, d0;
    wr(OFS_CTRL, 32'h0);
    td(7, 32'h00F0_0070, cfg(12'd12, 3'd7, 7'h63));
    wr(OFS_TD_INIT, 32'h7);
    w0 = mem_u.wr_n; d0 = done_n;
    wr(OFS_CTRL, ctl(2'd0, 7'd12, 3'b101));
    wait_wr(w0 + 1);
    trq <= 1'b1;
    repeat (2) @(posedge mclk);
    trq <= 1'b0;
    wait_idle;
    chk("stopped", 32'(mem_u.wr_n - w0 < 12), 32'd1);
    chk("no done", 32'(done_n - d0), 32'd0);
  endtask
  // Main sequence
  initial begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 10'h000;
    reg_wdata = 32'h0; drq = 1'b0; drq_is_level = 1'b0; trq = 1'b0; hold_off = 1'b0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_copy;
    t_rpb;
    t_swap;
    t_chain;
    t_stall;
    t_term;
    end_of_test;
  end
  // Watchdog
  initial begin
    #300000;
    fail_count++;
    end_of_test;
  end
endmodule // test_dcdma_channel
`default_nettype wire
